//--- rtl/rmp_core.sv
// Reading math processor for an eight-input temperature monitor: curve
// assignment, smoothing, linear equation, max/min tracker, analog outputs.
// Assumes readings arrive as a valid-qualified stream on sys_clk and an
// AHB-Lite master owns the register bus; the slave never waits.
// Notes on behaviour
// - No curve: sensor units only.
// - Curve must suit the group sensor type.
// - One 200-point user curve per input slot.
// - User curve assignable only to own input.
// - Math configured separately for each input.
// - Tracker keeps largest and smallest reading.
// - Tracker follows one input and source.
// - Clear at reset or tracked input change.
// - Manual clear clears both extremes.
// - Linear result is slope times reading plus offset.
// - Linear source is kelvin, celsius or sensor.
// - Slope default one, offset default zero.
// - Filter enabled smooths, disabled passes raw.
// - Every raw reading yields a result.
// - Filter length is 2 to 64 readings.
// - Step settles in about six lengths.
// - Jump beyond window restarts the filter.
// - Window is 1 to 10 percent full scale.
// - Outputs are 14-bit codes, 1.25 mV steps.
// - Each output is off, input or manual.
// - Off output gives zero volts.
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "rmp_cfg.svh"

module rmp_core (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 resetn,
	// AHB-Lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	// Raw reading stream
	input  wire logic                 rd_valid,
	input  wire rmp_pkg::rmp_reading_t rd,
	// Processed reading stream
	output logic                      res_valid,
	output rmp_pkg::rmp_result_t      res,
	// Analog output converter codes
	output logic [13:0]               dac_code0,
	output logic [13:0]               dac_code1
);

	// Curve is legal for this input under this group sensor type
	function automatic logic curve_ok(input logic [4:0] cv, input logic [2:0] ch,
		input logic [2:0] st);
		logic ok;
		ok = 1'b0;
		if (cv == `RMP_CURVE_NONE)
			ok = 1'b1;
		else if (cv == `RMP_USER_BASE + 5'(ch) + 5'h01)
			ok = 1'b1;
		else if (cv >= 5'h01 && cv <= 5'h04)
			ok = (st == 3'h0);                       // Diode curves
		else if (cv == 5'h06)
			ok = (st == 3'h2) || (st == 3'h3);       // 100 ohm platinum
		else if (cv == 5'h07)
			ok = (st == 3'h4);                       // 1000 ohm platinum
		return ok;
	endfunction : curve_ok

	// One smoothing step; restart or bypass loads the raw value
	function automatic logic signed [31:0] filt_step(input logic signed [31:0] prev,
		input logic signed [31:0] raw, input logic en, input logic primed,
		input logic [6:0] pts, input logic [3:0] win);
		logic signed [31:0] diff;
		logic signed [31:0] mag;
		logic signed [31:0] thr;
		logic signed [31:0] outv;
		diff = raw - prev;
		mag  = diff[31] ? -diff : diff;
		thr  = 32'(($signed(`RMP_FULL_SCALE) / 32'sh0000_0064) * $signed({28'h0, win}));
		if (!en || !primed)
			outv = raw;
		else if (mag > thr)
			outv = raw;
		else
			outv = prev + diff / $signed({25'h0, pts});
		return outv;
	endfunction : filt_step

	// Pick one source value
	function automatic logic signed [31:0] src_sel(input logic [1:0] s,
		input logic signed [31:0] k, input logic signed [31:0] c,
		input logic signed [31:0] sn, input logic signed [31:0] l);
		return (s == 2'h0) ? k : (s == 2'h1) ? c : (s == 2'h2) ? sn : l;
	endfunction : src_sel

	// Analog output code from a reading; clamped to the converter span
	function automatic logic [13:0] ao_code(input logic signed [31:0] v);
		logic signed [63:0] c;
		// Every operand stays signed, so negative readings land below mid-scale
		c = 64'($signed(v)) / $signed(`RMP_AOUT_DIV) + $signed(64'(`RMP_DAC_ZERO));
		if (c < 64'sh0)
			return 14'h0000;
		else if (c > 64'($signed({1'b0, `RMP_DAC_MAX})))
			return `RMP_DAC_MAX;
		return c[13:0];
	endfunction : ao_code

	// Per-input configuration
	logic [4:0]         in_curve   [8];   // Assigned curve number
	logic               in_filt_en [8];   // Smoothing on
	logic [1:0]         in_lin_src [8];   // Linear X source
	logic [6:0]         in_pts     [8];   // Filter points
	logic [3:0]         in_win     [8];   // Restart window percent
	logic signed [31:0] in_m       [8];   // Slope
	logic signed [31:0] in_b       [8];   // Offset
	// Filter state and latest results
	logic signed [31:0] filt_k [8];
	logic signed [31:0] filt_c [8];
	logic signed [31:0] filt_s [8];
	logic               primed [8];       // Filter holds a value
	logic signed [31:0] last_k [8];
	logic signed [31:0] last_c [8];
	logic signed [31:0] last_s [8];
	logic signed [31:0] last_l [8];
	// User curve storage, one slot of points per input
	logic [31:0]        curve_mem [`RMP_CURVE_WORDS];
	logic [2:0]         curve_slot;
	logic [7:0]         curve_pt;
	// Global control
	logic [2:0]         grp_type [2];     // Sensor type of inputs 1-4 and 5-8
	logic [2:0]         trk_in;           // Tracked input
	logic [1:0]         trk_src;          // Tracked source
	logic               cfg_reject;       // Last curve write refused
	logic               mm_valid;         // Extremes hold a reading
	logic signed [31:0] mm_max;
	logic signed [31:0] mm_min;
	logic [1:0]         ao_mode   [2];
	logic [2:0]         ao_in     [2];
	logic [1:0]         ao_src    [2];
	logic [13:0]        ao_manual [2];
	// Bus data phase
	logic               dp_write;
	logic               dp_read;
	logic [11:0]        dp_addr;
	// Pipeline stage 1: filtered values
	logic               s1_valid;
	logic [2:0]         s1_chan;
	logic signed [31:0] s1_k;
	logic signed [31:0] s1_c;
	logic signed [31:0] s1_s;

	// Bus decode
	wire        ap_take   = hsel && htrans[1] && hready;
	wire        wr_en     = dp_write;
	wire        in_hit    = (dp_addr >= `RMP_OFS_IN_BASE) && (dp_addr <= `RMP_OFS_IN_END);
	wire [2:0]  in_idx    = 3'(dp_addr[8:5] - 4'h1);
	wire [2:0]  in_word   = dp_addr[4:2];
	wire        wr_in_cfg = wr_en && in_hit && (in_word == `RMP_IN_CFG);
	wire        wr_in_m   = wr_en && in_hit && (in_word == `RMP_IN_M);
	wire        wr_in_b   = wr_en && in_hit && (in_word == `RMP_IN_B);
	wire        wr_ctrl   = wr_en && (dp_addr == `RMP_OFS_CTRL);
	wire [2:0]  wr_type   = grp_type[in_idx[2]];
	wire        cv_legal  = curve_ok(hwdata[4:0], in_idx, wr_type);
	wire [6:0]  wr_pts    = (hwdata[14:8] < `RMP_PTS_MIN) ? `RMP_PTS_MIN :
		(hwdata[14:8] > `RMP_PTS_MAX) ? `RMP_PTS_MAX : hwdata[14:8];
	wire [3:0]  wr_win    = (hwdata[19:16] < `RMP_WIN_MIN) ? `RMP_WIN_MIN :
		(hwdata[19:16] > `RMP_WIN_MAX) ? `RMP_WIN_MAX : hwdata[19:16];
	wire [1:0]  wr_lsrc   = (hwdata[7:6] == 2'h3) ? 2'h0 : hwdata[7:6];
	wire [10:0] cidx      = 11'(curve_slot) * 11'(`RMP_CURVE_PTS) + 11'(curve_pt);
	wire        cpt_ok    = curve_pt < 8'(`RMP_CURVE_PTS);

	// Clearing of extremes: manual, tracker retarget, tracked input edited
	wire mm_clear = wr_ctrl ||
		(wr_en && in_hit && in_word <= `RMP_IN_B && in_idx == trk_in);

	// Stage 1 filter results for the arriving reading
	wire signed [31:0] nf_k = filt_step(filt_k[rd.chan], rd.kelvin, in_filt_en[rd.chan],
		primed[rd.chan], in_pts[rd.chan], in_win[rd.chan]);
	wire signed [31:0] nf_c = filt_step(filt_c[rd.chan], rd.celsius, in_filt_en[rd.chan],
		primed[rd.chan], in_pts[rd.chan], in_win[rd.chan]);
	wire signed [31:0] nf_s = filt_step(filt_s[rd.chan], rd.sensor, in_filt_en[rd.chan],
		primed[rd.chan], in_pts[rd.chan], in_win[rd.chan]);

	// Stage 2 linear equation and temperature availability
	wire               s1_temp = in_curve[s1_chan] != `RMP_CURVE_NONE;
	wire signed [31:0] s1_kq   = s1_temp ? s1_k : 32'sh0;
	wire signed [31:0] s1_cq   = s1_temp ? s1_c : 32'sh0;
	wire signed [31:0] lin_x   = src_sel(in_lin_src[s1_chan], s1_kq, s1_cq, s1_s, s1_s);
	wire signed [63:0] lin_p   = 64'(in_m[s1_chan]) * 64'(lin_x);
	wire signed [31:0] lin_y   = 32'(lin_p / $signed(`RMP_ONE_W)) + in_b[s1_chan];
	wire signed [31:0] trk_v   = src_sel(trk_src, s1_kq, s1_cq, s1_s, lin_y);
	// Temperature sources are skipped by the tracker when no curve is set
	wire trk_take = s1_valid && (s1_chan == trk_in) &&
		(s1_temp || trk_src == 2'h2 || (trk_src == 2'h3 && in_lin_src[s1_chan] == 2'h2));

	// Register read mux
	wire [31:0] rd_in_cfg = {12'h0, in_win[in_idx], 1'b0, in_pts[in_idx],
		in_lin_src[in_idx], in_filt_en[in_idx], in_curve[in_idx]};
	wire [31:0] rd_in = (in_word == `RMP_IN_CFG) ? rd_in_cfg :
		(in_word == `RMP_IN_M)   ? in_m[in_idx]   :
		(in_word == `RMP_IN_B)   ? in_b[in_idx]   :
		(in_word == `RMP_IN_LIN) ? last_l[in_idx] :
		(in_word == `RMP_IN_K)   ? last_k[in_idx] :
		(in_word == `RMP_IN_C)   ? last_c[in_idx] :
		(in_word == `RMP_IN_S)   ? last_s[in_idx] : 32'h0000_0000;
	wire [31:0] rd_ao0 = {2'h0, ao_manual[0], 6'h0, ao_src[0], 1'b0, ao_in[0], 2'h0, ao_mode[0]};
	wire [31:0] rd_ao1 = {2'h0, ao_manual[1], 6'h0, ao_src[1], 1'b0, ao_in[1], 2'h0, ao_mode[1]};
	wire [31:0] rd_word =
		(dp_addr == `RMP_OFS_CTRL)  ? {10'h0, trk_src, 1'b0, trk_in, 1'b0, grp_type[1],
			1'b0, grp_type[0], 8'h00} :
		(dp_addr == `RMP_OFS_STAT)  ? {30'h0, cfg_reject, mm_valid} :
		(dp_addr == `RMP_OFS_MAX)   ? mm_max :
		(dp_addr == `RMP_OFS_MIN)   ? mm_min :
		(dp_addr == `RMP_OFS_CADDR) ? {16'h0, curve_pt, 5'h0, curve_slot} :
		(dp_addr == `RMP_OFS_CDATA) ? (cpt_ok ? curve_mem[cidx] : 32'h0000_0000) :
		(dp_addr == `RMP_OFS_AOUT0) ? rd_ao0 :
		(dp_addr == `RMP_OFS_AOUT1) ? rd_ao1 :
		in_hit ? rd_in : 32'h0000_0000;   // Unmapped reads as zero

	// Slave is always ready and always answers OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = dp_read ? rd_word : 32'h0000_0000;

	// Capture the address phase; only whole-word writes are taken, reads are taken at any size
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			dp_write <= 1'b0;
			dp_read  <= 1'b0;
			dp_addr  <= 12'h000;
		end else begin
			dp_write <= ap_take && hwrite && (hsize == 3'h2);
			dp_read  <= ap_take && !hwrite;
			dp_addr  <= {haddr[11:2], 2'h0};
		end
	end

	// Global control registers
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			grp_type[0] <= 3'h0;
			grp_type[1] <= 3'h0;
			trk_in      <= 3'h0;
			trk_src     <= 2'h0;
			curve_slot  <= 3'h0;
			curve_pt    <= 8'h00;
			cfg_reject  <= 1'b0;
			for (int i = 0; i < 2; i++) begin
				ao_mode[i]   <= 2'h0;
				ao_in[i]     <= 3'h0;
				ao_src[i]    <= 2'h0;
				ao_manual[i] <= `RMP_DAC_ZERO;
			end
		end else begin
			if (wr_ctrl) begin
				grp_type[0] <= hwdata[10:8];
				grp_type[1] <= hwdata[14:12];
				trk_in      <= hwdata[18:16];
				trk_src     <= hwdata[21:20];
			end
			// Curve pointer steps after each data access below the end of the slot, for bulk loading
			if (wr_en && dp_addr == `RMP_OFS_CADDR) begin
				curve_slot <= hwdata[2:0];
				curve_pt   <= hwdata[15:8];
			end else if ((wr_en || dp_read) && dp_addr == `RMP_OFS_CDATA && cpt_ok)
				curve_pt <= curve_pt + 8'h01;
			if (wr_in_cfg)
				cfg_reject <= !cv_legal;
			for (int i = 0; i < 2; i++) begin
				if (wr_en && dp_addr == (i == 0 ? `RMP_OFS_AOUT0 : `RMP_OFS_AOUT1)) begin
					ao_mode[i]   <= (hwdata[1:0] == 2'h3) ? 2'h0 : hwdata[1:0];
					ao_in[i]     <= hwdata[6:4];
					ao_src[i]    <= hwdata[9:8];
					ao_manual[i] <= (hwdata[29:16] > `RMP_DAC_MAX) ? `RMP_DAC_MAX : hwdata[29:16];
				end
			end
		end
	end

	// User curve points; contents are not reset
	always_ff @(posedge sys_clk) begin
		if (wr_en && dp_addr == `RMP_OFS_CDATA && cpt_ok)
			curve_mem[cidx] <= hwdata;
	end

	// Per-input configuration; a refused curve keeps the old one
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			for (int i = 0; i < `RMP_NUM_IN; i++) begin
				in_curve[i]   <= `RMP_CURVE_NONE;
				in_filt_en[i] <= 1'b0;
				in_lin_src[i] <= 2'h0;
				in_pts[i]     <= `RMP_PTS_RST;
				in_win[i]     <= `RMP_WIN_RST;
				in_m[i]       <= `RMP_M_RST;
				in_b[i]       <= `RMP_B_RST;
			end
		end else begin
			if (wr_in_cfg) begin
				if (cv_legal)
					in_curve[in_idx] <= hwdata[4:0];
				in_filt_en[in_idx] <= hwdata[5];
				in_lin_src[in_idx] <= wr_lsrc;
				in_pts[in_idx]     <= wr_pts;
				in_win[in_idx]     <= wr_win;
			end
			if (wr_in_m)
				in_m[in_idx] <= hwdata;
			if (wr_in_b)
				in_b[in_idx] <= hwdata;
		end
	end

	// Stage 1: smoothing, one result per raw reading, no rate loss
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s1_valid <= 1'b0;
			s1_chan  <= 3'h0;
			s1_k     <= 32'sh0;
			s1_c     <= 32'sh0;
			s1_s     <= 32'sh0;
			for (int i = 0; i < `RMP_NUM_IN; i++) begin
				filt_k[i] <= 32'sh0;
				filt_c[i] <= 32'sh0;
				filt_s[i] <= 32'sh0;
				primed[i] <= 1'b0;
			end
		end else begin
			s1_valid <= rd_valid;
			if (rd_valid) begin
				s1_chan        <= rd.chan;
				s1_k           <= nf_k;
				s1_c           <= nf_c;
				s1_s           <= nf_s;
				filt_k[rd.chan] <= nf_k;
				filt_c[rd.chan] <= nf_c;
				filt_s[rd.chan] <= nf_s;
				primed[rd.chan] <= 1'b1;
			end
			// Retuning a filter starts it afresh, unless a reading of that input lands in the same cycle
			if (wr_in_cfg && !(rd_valid && rd.chan == in_idx))
				primed[in_idx] <= 1'b0;
		end
	end

	// Stage 2: results, latest values and extremes
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			res_valid <= 1'b0;
			res       <= '0;
			mm_valid  <= 1'b0;
			mm_max    <= 32'sh0;
			mm_min    <= 32'sh0;
			for (int i = 0; i < `RMP_NUM_IN; i++) begin
				last_k[i] <= 32'sh0;
				last_c[i] <= 32'sh0;
				last_s[i] <= 32'sh0;
				last_l[i] <= 32'sh0;
			end
		end else begin
			res_valid <= s1_valid;
			if (s1_valid) begin
				res            <= '{s1_chan, s1_temp, s1_kq, s1_cq, s1_s, lin_y};
				last_k[s1_chan] <= s1_kq;
				last_c[s1_chan] <= s1_cq;
				last_s[s1_chan] <= s1_s;
				last_l[s1_chan] <= lin_y;
			end
			// A reading landing with a clear is the first after it
			if (trk_take && (mm_clear || !mm_valid)) begin
				mm_valid <= 1'b1;
				mm_max   <= trk_v;
				mm_min   <= trk_v;
			end else if (trk_take) begin
				if (trk_v > mm_max)
					mm_max <= trk_v;
				if (trk_v < mm_min)
					mm_min <= trk_v;
			end else if (mm_clear)
				mm_valid <= 1'b0;
		end
	end

	// Analog output codes
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			dac_code0 <= `RMP_DAC_ZERO;
			dac_code1 <= `RMP_DAC_ZERO;
		end else begin
			dac_code0 <= (ao_mode[0] == 2'h1) ? ao_code(src_sel(ao_src[0], last_k[ao_in[0]],
				last_c[ao_in[0]], last_s[ao_in[0]], last_l[ao_in[0]])) :
				(ao_mode[0] == 2'h2) ? ao_manual[0] : `RMP_DAC_ZERO;
			dac_code1 <= (ao_mode[1] == 2'h1) ? ao_code(src_sel(ao_src[1], last_k[ao_in[1]],
				last_c[ao_in[1]], last_s[ao_in[1]], last_l[ao_in[1]])) :
				(ao_mode[1] == 2'h2) ? ao_manual[1] : `RMP_DAC_ZERO;
		end
	end

endmodule : rmp_core

//--- rtl/rmp_cfg.svh
// Constants of the reading math processor: register offsets, fields,
// reset values and fixed figures. Definitions only, no logic.
`ifndef RMP_CFG_SVH
`define RMP_CFG_SVH

// Fixed-point scale: values carry four decimal places
`define RMP_ONE          32'h0000_2710
`define RMP_ONE_W        64'h0000_0000_0000_2710
`define RMP_FULL_SCALE   32'h05F5_E100
`define RMP_NUM_IN       8
`define RMP_CURVE_PTS    200
`define RMP_CURVE_WORDS  1600
// Curve numbers: 0 none, 1..7 standard, 21..28 user slots of inputs 1..8
`define RMP_CURVE_NONE   5'h00
`define RMP_USER_BASE    5'h14
// Filter limits and defaults
`define RMP_PTS_MIN      7'h02
`define RMP_PTS_MAX      7'h40
`define RMP_PTS_RST      7'h08
`define RMP_WIN_MIN      4'h1
`define RMP_WIN_MAX      4'hA
`define RMP_WIN_RST      4'h1
// Linear defaults: slope +1.0000, offset +0.0000
`define RMP_M_RST        32'h0000_2710
`define RMP_B_RST        32'h0000_0000
// Analog output codes: 1.25 mV per step, -10 V at code 0
`define RMP_DAC_ZERO     14'h1F40
`define RMP_DAC_MAX      14'h3E80
`define RMP_AOUT_DIV     64'h0000_0000_0000_2710
// Register byte offsets (address bits 11:0)
`define RMP_OFS_CTRL     12'h000
`define RMP_OFS_STAT     12'h004
`define RMP_OFS_MAX      12'h008
`define RMP_OFS_MIN      12'h00C
`define RMP_OFS_CADDR    12'h010
`define RMP_OFS_CDATA    12'h014
`define RMP_OFS_AOUT0    12'h018
`define RMP_OFS_AOUT1    12'h01C
`define RMP_OFS_IN_BASE  12'h020
`define RMP_OFS_IN_END   12'h11F
// Per-input word index within a 32-byte block
`define RMP_IN_CFG       3'h0
`define RMP_IN_M         3'h1
`define RMP_IN_B         3'h2
`define RMP_IN_LIN       3'h3
`define RMP_IN_K         3'h4
`define RMP_IN_C         3'h5
`define RMP_IN_S         3'h6

`endif

//--- rtl/rmp_pkg.sv
// Types of the reading math processor: sources, modes and stream words.
// Assumes rmp_cfg.svh for all numeric constants.
package rmp_pkg;

	// Reading source used by linear equation, tracker and analog outputs
	typedef enum logic [1:0] {
		RMP_SRC_K,
		RMP_SRC_C,
		RMP_SRC_S,
		RMP_SRC_LIN
	} rmp_src_t;

	// Analog output mode
	typedef enum logic [1:0] {
		RMP_AO_OFF,
		RMP_AO_INPUT,
		RMP_AO_MANUAL
	} rmp_ao_mode_t;

	// One raw reading from the measurement path
	typedef struct packed {
		logic [2:0]         chan;
		logic signed [31:0] kelvin;
		logic signed [31:0] celsius;
		logic signed [31:0] sensor;
	} rmp_reading_t;

	// One processed reading to the display path
	typedef struct packed {
		logic [2:0]         chan;
		logic               temp_ok;
		logic signed [31:0] kelvin;
		logic signed [31:0] celsius;
		logic signed [31:0] sensor;
		logic signed [31:0] linear;
	} rmp_result_t;

endpackage : rmp_pkg

//--- test/rmp_sense_model.sv
// Partner model of the measurement path: one reading per bench request.
// Assumes the bench raises go for one cycle with the reading and a delay.
`timescale 1ns/1ps

module rmp_sense_model (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  resetn,
	// Request from the bench
	input  wire logic                  go,
	input  wire logic [3:0]            gap,
	input  wire rmp_pkg::rmp_reading_t val,
	// Reading stream into the block
	output logic                       rd_valid,
	output rmp_pkg::rmp_reading_t      rd
);
	logic [3:0]            cnt;  // Cycles left before the reading goes out
	logic                  busy; // A reading is waiting
	rmp_pkg::rmp_reading_t hold; // Reading being delayed
	wire                   fire = busy && !go && (cnt == 4'h0); // Reading goes out now

	// Slow answers wait gap cycles; between readings the lines toggle so
	// that stale data can never pass for a fresh reading
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			busy     <= 1'b0;
			cnt      <= 4'h0;
			rd_valid <= 1'b0;
			rd       <= '0;
		end else begin
			rd_valid <= fire;
			rd       <= fire ? hold : ~rd;
			if (go) begin
				busy <= 1'b1;
				cnt  <= gap;
				hold <= val;
			end else if (busy && cnt != 4'h0)
				cnt <= cnt - 4'h1;
			else if (busy)
				busy <= 1'b0;
		end
	end
endmodule : rmp_sense_model

//--- test/rmp_core_monitor.sv
// Concurrent checks on the ports of the reading math processor.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps

module rmp_core_monitor (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  resetn,
	// Bus request side
	input  wire logic                  hsel,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic                  hready,
	// Reading streams
	input  wire logic                  rd_valid,
	input  wire rmp_pkg::rmp_reading_t rd,
	input  wire logic                  res_valid,
	input  wire rmp_pkg::rmp_result_t  res,
	// Converter codes
	input  wire logic [13:0]           dac_code0,
	input  wire logic [13:0]           dac_code1
);
	logic wr_ph; // Write data phase under way

	// Tracks write data phases, the only bus cause of a code change
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			wr_ph <= 1'b0;
		else
			wr_ph <= hsel & htrans[1] & hready & hwrite;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_res_lat: assert property (rd_valid |-> ##2 res_valid)
		else $error("no result two cycles after a reading");
	a_res_cause: assert property (res_valid |-> $past(rd_valid, 2))
		else $error("result without a reading");
	a_res_chan: assert property (rd_valid |-> ##2 res.chan == $past(rd.chan, 2))
		else $error("result carries the wrong input");
	a_no_temp: assert property (res_valid && !res.temp_ok |->
		res.kelvin == 32'h0 && res.celsius == 32'h0)
		else $error("temperature reported without a curve");
	a_res_hold: assert property (!res_valid |-> $stable(res))
		else $error("result moved without a valid pulse");
	a_dac_range: assert property (dac_code0 <= 14'h3E80 && dac_code1 <= 14'h3E80)
		else $error("converter code beyond full scale");
	a_reset_codes: assert property ($rose(resetn) |->
		dac_code0 == 14'h1F40 && dac_code1 == 14'h1F40 && !res_valid)
		else $error("outputs not at zero volts after reset");
	a_dac_cause: assert property ($changed({dac_code0, dac_code1}) |->
		$past(wr_ph) || $past(wr_ph, 2) || $past(res_valid) || $past(res_valid, 2))
		else $error("converter code changed without a cause");

	c_no_curve: cover property (res_valid && !res.temp_ok);
	c_curve: cover property (res_valid && res.temp_ok);
	c_code_move: cover property ($changed(dac_code0));
endmodule : rmp_core_monitor

bind rmp_core rmp_core_monitor u_mon (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .rd_valid(rd_valid), .rd(rd),
	.res_valid(res_valid), .res(res), .dac_code0(dac_code0), .dac_code1(dac_code1));

//--- test/reading_math_processor_tb.sv
// Self-checking bench of the reading math processor: registers over the
// bus, readings from the partner model, results checked from a queue.
`timescale 1ns/1ps

module reading_math_processor_tb;
	logic                  sys_clk = 1'b0; // 200 MHz clock
	logic                  resetn  = 1'b0; // Synchronous reset
	logic                  hsel    = 1'b0; // Bus request
	logic                  hwrite  = 1'b0;
	logic [1:0]            htrans  = 2'h0;
	logic [2:0]            hsize   = 3'h2; // Whole words only
	logic [31:0]           haddr   = 32'h0;
	logic [31:0]           hwdata  = 32'h0;
	logic [31:0]           hrdata, q, seed;
	logic                  hreadyout, hresp, rd_valid, res_valid;
	logic                  go      = 1'b0; // Request to the partner
	logic [3:0]            gap     = 4'h0;
	logic [13:0]           dac0, dac1;
	rmp_pkg::rmp_reading_t val     = '0;
	rmp_pkg::rmp_reading_t rd;
	rmp_pkg::rmp_result_t  res, ex;
	rmp_pkg::rmp_result_t  exq[$]; // Expected results, oldest first
	int                    error_cnt = 0, n_compared = 0;
	int                    cv[4] = '{5, 22, 6, 21}; // Curves tried on input 1

	always #2.5 sys_clk = ~sys_clk;

	rmp_core dut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.rd_valid(rd_valid), .rd(rd), .res_valid(res_valid), .res(res),
		.dac_code0(dac0), .dac_code1(dac1));
	rmp_sense_model u_sense (.sys_clk(sys_clk), .resetn(resetn), .go(go), .gap(gap),
		.val(val), .rd_valid(rd_valid), .rd(rd));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One single transfer; read data taken at the end of the data phase
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus

	task automatic rchk(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rchk

	// Input 1 has a curve, slope 2 and offset 5000; input 2 has neither
	task automatic send(input logic [2:0] ch, input logic signed [31:0] s,
		input logic signed [31:0] fs, input logic [3:0] g);
		ex         = '0;
		ex.chan    = ch;
		ex.temp_ok = (ch == 3'h0);
		ex.kelvin  = (ch == 3'h0) ? fs : 32'sh0;
		ex.celsius = (ch == 3'h0) ? fs : 32'sh0;
		ex.sensor  = fs;
		ex.linear  = (ch == 3'h0) ? fs * 2 + 5000 : fs;
		exq.push_back(ex);
		@(posedge sys_clk);
		go  <= 1'b1;
		gap <= g;
		val <= '{ch, s, s, s};
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (g + 4) @(posedge sys_clk);
	endtask : send

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	// Scoreboard: each result takes the oldest expectation
	always @(posedge sys_clk) begin
		if (res_valid === 1'b1) begin
			if (exq.size() == 0)
				chk(32'h1, 32'h0);
			else begin
				ex = exq.pop_front();
				chk({29'h0, res.chan}, {29'h0, ex.chan});
				chk({31'h0, res.temp_ok}, {31'h0, ex.temp_ok});
				chk(res.kelvin, ex.kelvin);
				chk(res.celsius, ex.celsius);
				chk(res.sensor, ex.sensor);
				chk(res.linear, ex.linear);
			end
		end
	end

	// Hang guard, well beyond the few hundred cycles of the sequence
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		wrap_up();
	end

	initial begin
		seed = 32'hC582D854;
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		chk({18'h0, dac0}, 32'h1F40);
		rchk(32'h4, 32'h0);
		rchk(32'h24, 32'h2710);
		rchk(32'h28, 32'h0);
		bus(1'b1, 32'h20, 32'h81);
		bus(1'b1, 32'h24, 32'h4E20);
		bus(1'b1, 32'h28, 32'h1388);
		bus(1'b1, 32'h40, 32'h80);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			send(3'h0, seed & 32'hFFFF, seed & 32'hFFFF, 4'(i));
		end
		send(3'h1, 7, 7, 4'h0);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 32'h20, 32'h80 + cv[i]);
			rchk(32'h4, (i < 3) ? 32'h2 : 32'h0);
		end
		// Last point of the fourth user slot, then the end of that slot
		bus(1'b1, 32'h10, 32'hC703);
		bus(1'b1, 32'h14, seed);
		rchk(32'h14, 32'h0);
		bus(1'b1, 32'h10, 32'hC703);
		rchk(32'h14, seed);
		rchk(32'h10, 32'hC803);
		bus(1'b1, 32'h20, 32'h102B5);
		send(3'h0, 1000, 1000, 4'h0);
		send(3'h0, 1400, 1200, 4'h0);
		send(3'h0, 1201, 1200, 4'h0);
		send(3'h0, 3000000, 3000000, 4'h0);
		send(3'h0, 2000001, 2500001, 4'h0);
		bus(1'b1, 32'h20, 32'h40B5);
		send(3'h0, 0, 0, 4'h0);
		send(3'h0, 6400, 100, 4'h0);
		bus(1'b1, 32'h0, 32'h200000);
		bus(1'b1, 32'h20, 32'h95);
		send(3'h0, 500, 500, 4'h0);
		send(3'h0, 300, 300, 4'h0);
		send(3'h0, 900, 900, 4'h0);
		rchk(32'h8, 32'd900);
		rchk(32'hC, 32'd300);
		rchk(32'h4, 32'h1);
		bus(1'b1, 32'h28, 32'h1388);
		rchk(32'h4, 32'h0);
		send(3'h0, 700, 700, 4'h0);
		rchk(32'h8, 32'd700);
		rchk(32'hC, 32'd700);
		bus(1'b1, 32'h0, 32'h200000);
		rchk(32'h4, 32'h0);
		bus(1'b1, 32'h18, 32'h04D20002);
		bus(1'b1, 32'h1C, 32'h201);
		send(3'h0, 30000000, 30000000, 4'h0);
		repeat (3) @(posedge sys_clk);
		chk({18'h0, dac0}, 32'd1234);
		chk({18'h0, dac1}, 32'd11000);
		// A negative reading must land below mid-scale
		send(3'h0, -30000000, -30000000, 4'h0);
		repeat (3) @(posedge sys_clk);
		chk({18'h0, dac1}, 32'd5000);
		bus(1'b1, 32'h18, 32'h0);
		repeat (3) @(posedge sys_clk);
		chk({18'h0, dac0}, 32'h1F40);
		repeat (10) @(posedge sys_clk);
		chk(32'(exq.size()), 32'h0);
		wrap_up();
	end
endmodule : reading_math_processor_tb
